// File: hdl/esi_interlock.sv
// Contract
// R1 - stop input with interlock on blocks gate switching without firmware.
// R2 - stop only halts switching; never reported as output isolation.
// R3 - interlock on: terminals one and three dedicated, other functions ignored.
// R4 - terminal one is normally-open reset; asserting it clears stop trip.
// R5 - terminal three is normally-closed stop; open contact means stop.
// R6 - stop activation latches a trip showing the emergency-stop code.
// R7 - unconnected, broken or wrong-polarity terminal three also trips.
// R8 - only terminal one reset releases the stop trip.
// R9 - keypad clear requests ignored while stop trip latched.
// R10 - interlock enabled only by switch on; switch defaults off.
// R11 - switch on forces term1 18/00, term3 64/01, locked while on.
// R12 - keypad may never assign code 64 to terminal three.
// R13 - code 18 on any terminal forces its polarity to 00.
// R14 - on enable other terminals holding 18 become no function.
// R15 - switch off frees settings; term3 function none, polarity kept 01.
// R16 - each of eight terminals takes one code from selectable set.
// R17 - inputs synchronised; stop-to-gate path combinational and clockless.
// R18 - trip holds while stop open, clears on reset with contact closed.
// R19 - safety circuit holds term3 closed, opens to stop, pulses term1.
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module esi_interlock
   import esi_pkg::*;
#(
   parameter int NUM_GATE = 6
)
(
   // clock and reset
   input  wire logic                        sys_clk,
   input  wire logic                        resetn,
   // terminal pins and switch, high = contact closed
   input  wire logic [esi_pkg::NUM_TERM-1:0] term_in,
   input  wire logic                        interlock_enable_switch,
   // power stage gates
   input  wire logic [NUM_GATE-1:0]          gate_cmd_in,
   output logic      [NUM_GATE-1:0]          gate_cmd_out,
   output logic                             switching_halted,
   // drive status
   output logic                             drive_reset,
   output logic      [7:0]                  estop_trip_code,
   output logic                             interlock_active,
   output logic                             irq,
   // register bus
   input  wire esi_pkg::esi_axi_req_t        axi_req,
   output esi_pkg::esi_axi_rsp_t             axi_rsp
);
   import esi_pkg::*;

   generate
      if (NUM_GATE < 1)
      begin : g_chk
         $error("NUM_GATE must be at least one");
      end
   endgenerate

   esi_state_t q;
   esi_state_t d;

   logic              stop_raw;
   logic              en;
   logic [NUM_TERM-1:0] t;
   logic              stop_act;
   logic              aw_hs;
   logic              w_hs;
   logic              ar_hs;
   logic              do_wr;
   logic [ADDR_W-1:0] wa;
   logic [31:0]       wd;
   logic [3:0]        ws;
   logic [NUM_IRQ-1:0] ev;
   logic [NUM_IRQ-1:0] w1c;
   logic [31:0]       rd;
   logic [1:0]        rr;
   logic [7:0]        code;
   logic [1:0]        pv;
   int                idx;

   // terminal locked to the interlock while the switch is on
   function automatic logic locked(input int i, input logic on);
      locked = on && (i == IDX_RST || i == IDX_STOP); // see R3 see R11
   endfunction

   function automatic logic func_ok(input int i, input logic [7:0] c,
                                    input logic on);
      logic sel;
      sel = (c <= FN_MAX) || (c == FN_NONE); // see R16
      func_ok = sel && !locked(i, on) && !(i == IDX_STOP && c == FN_ESTOP); // see R12
   endfunction

   // raw pins on purpose: gate block must not wait on clock or firmware
   assign stop_raw = interlock_enable_switch & ~term_in[IDX_STOP]; // see R1 see R5 see R17
   assign switching_halted = stop_raw | q.trip; // see R2
   assign gate_cmd_out = switching_halted ? '0 : gate_cmd_in; // see R1

   assign drive_reset      = q.drive_reset;
   assign estop_trip_code  = q.trip_code;
   assign interlock_active = q.sync2[IDX_SW];
   assign irq              = |(q.irq_stat & q.irq_mask);

   assign aw_hs = axi_req.awvalid & axi_rsp.awready;
   assign w_hs  = axi_req.wvalid & axi_rsp.wready;
   assign ar_hs = axi_req.arvalid & axi_rsp.arready;

   always_comb
   begin
      axi_rsp         = '0;
      axi_rsp.awready = ~q.aw_got & ~q.bvalid;
      axi_rsp.wready  = ~q.w_got & ~q.bvalid;
      axi_rsp.bvalid  = q.bvalid;
      axi_rsp.bresp   = q.bresp;
      axi_rsp.arready = ~q.rvalid;
      axi_rsp.rvalid  = q.rvalid;
      axi_rsp.rdata   = q.rdata;
      axi_rsp.rresp   = q.rresp;
   end

   always_comb
   begin
      idx  = 0;
      code = 8'h00;
      pv   = 2'h0;
      d    = q;
      ev   = '0;
      w1c  = '0;
      rd   = 32'h0000_0000;
      rr   = RESP_OKAY;
      d.drive_reset = 1'b0;

      d.sync1 = {interlock_enable_switch, term_in}; // see R17
      d.sync2 = q.sync1;
      d.prev  = q.sync2;
      en       = q.sync2[IDX_SW]; // see R10
      t        = q.sync2[NUM_TERM-1:0];
      stop_act = en & ~t[IDX_STOP]; // see R5 see R7

      // trip latch: stop wins over reset while the contact stays open
      if (stop_act)
      begin
         if (!q.trip)
         begin
            ev[IRQ_TRIP] = 1'b1;
         end
         d.trip = 1'b1; // see R6 see R18
      end
      else if (q.trip && t[IDX_RST])
      begin
         d.trip = 1'b0; // see R4 see R8 see R18
         d.drive_reset = 1'b1;
         ev[IRQ_CLEAR] = 1'b1;
      end
      else if (t[IDX_RST] && !q.prev[IDX_RST] &&
               q.func[IDX_RST] == FN_TRIP_RESET)
      begin
         d.drive_reset = 1'b1; // see R4
      end
      d.trip_code = d.trip ? ESTOP_TRIP_CODE : 8'h00; // see R6

      // write channel capture
      if (aw_hs)
      begin
         d.aw_got = 1'b1;
         d.awaddr = axi_req.awaddr;
      end
      if (w_hs)
      begin
         d.w_got = 1'b1;
         d.wdata = axi_req.wdata;
         d.wstrb = axi_req.wstrb;
      end
      wa = q.aw_got ? q.awaddr : axi_req.awaddr;
      wd = q.w_got ? q.wdata : axi_req.wdata;
      ws = q.w_got ? q.wstrb : axi_req.wstrb;
      do_wr = (q.aw_got | aw_hs) & (q.w_got | w_hs) & ~q.bvalid;

      if (do_wr)
      begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = RESP_OKAY;
         unique case (wa)
            ADDR_FUNC_LO, ADDR_FUNC_HI:
            begin
               for (int j = 0; j < 4; j++)
               begin
                  idx  = (wa == ADDR_FUNC_HI) ? j + 4 : j;
                  code = wd[8*j +: 8];
                  if (ws[j])
                  begin
                     if (func_ok(idx, code, en))
                     begin
                        d.func[idx] = code; // see R16
                        if (code == FN_TRIP_RESET)
                        begin
                           d.pol[idx] = POL_NO; // see R13
                        end
                     end
                     else
                     begin
                        ev[IRQ_CFG_REJ] = 1'b1; // see R3 see R12
                     end
                  end
               end
            end
            ADDR_POL:
            begin
               for (int i = 0; i < NUM_TERM; i++)
               begin
                  pv = wd[2*i +: 2];
                  if (ws[i/4])
                  begin
                     if (locked(i, en))
                     begin
                        ev[IRQ_CFG_REJ] = 1'b1; // see R11
                     end
                     else if (d.func[i] == FN_TRIP_RESET)
                     begin
                        d.pol[i] = POL_NO; // see R13
                     end
                     else
                     begin
                        d.pol[i] = pv;
                     end
                  end
               end
            end
            ADDR_IRQ_STAT:
            begin
               w1c = wd[NUM_IRQ-1:0] & {NUM_IRQ{ws[0]}};
            end
            ADDR_IRQ_MASK:
            begin
               if (ws[0])
               begin
                  d.irq_mask = wd[NUM_IRQ-1:0];
               end
            end
            ADDR_KEYPAD:
            begin
               if (ws[0] && wd[0])
               begin
                  if (q.trip)
                  begin
                     ev[IRQ_KP_REJ] = 1'b1; // see R9 see R8
                  end
                  else
                  begin
                     d.drive_reset = 1'b1;
                  end
               end
            end
            ADDR_STATUS:
            begin
               d.bresp = RESP_OKAY;
            end
            default:
            begin
               d.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (q.bvalid && axi_req.bready)
      begin
         d.bvalid = 1'b0;
      end

      // switch edges override a same-cycle write to the terminal settings they force
      if (en && !q.prev[IDX_SW])
      begin
         for (int i = 0; i < NUM_TERM; i++)
         begin
            if (i != IDX_RST && i != IDX_STOP && d.func[i] == FN_TRIP_RESET)
            begin
               d.func[i] = FN_NONE; // see R14
            end
         end
         d.func[IDX_RST]  = FN_TRIP_RESET; // see R11
         d.pol[IDX_RST]   = POL_NO;
         d.func[IDX_STOP] = FN_ESTOP;
         d.pol[IDX_STOP]  = POL_NC;
         ev[IRQ_SWITCH]   = 1'b1;
      end
      else if (!en && q.prev[IDX_SW])
      begin
         d.func[IDX_STOP] = FN_NONE; // see R15
         ev[IRQ_SWITCH]   = 1'b1;
      end

      // read channel
      unique case (axi_req.araddr)
         ADDR_FUNC_LO:  rd = q.func[3:0];
         ADDR_FUNC_HI:  rd = q.func[7:4];
         ADDR_POL:      rd = {16'h0000, q.pol};
         ADDR_STATUS:   rd = {8'h00, q.trip_code, t, 5'h00,
                              q.trip | stop_act, en, q.trip}; // see R2
         ADDR_IRQ_STAT: rd = {27'h0000000, q.irq_stat};
         ADDR_IRQ_MASK: rd = {27'h0000000, q.irq_mask};
         ADDR_KEYPAD:   rd = 32'h0000_0000;
         default:       rr = RESP_SLVERR;
      endcase
      if (q.rvalid && axi_req.rready)
      begin
         d.rvalid = 1'b0;
      end
      if (ar_hs)
      begin
         d.rvalid = 1'b1;
         d.rdata  = rd;
         d.rresp  = rr;
      end

      // new events beat a same-cycle clear
      d.irq_stat = (q.irq_stat & ~w1c) | ev;
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         q      <= '0;
         q.func <= FUNC_RESET; // see R10
      end
      else
      begin
         q <= d;
      end
   end

endmodule

// File: hdl/esi_pkg.sv
package esi_pkg;
   localparam int NUM_TERM = 8;
   localparam int ADDR_W   = 8;
   localparam int IDX_RST  = 0;
   localparam int IDX_STOP = 2;
   localparam int IDX_SW   = 8;

   // function, trip and polarity codes
   localparam logic [7:0] FN_TRIP_RESET = 8'h12;
   localparam logic [7:0] FN_ESTOP      = 8'h40;
   localparam logic [7:0] FN_JOG        = 8'h06;
   localparam logic [7:0] FN_NONE       = 8'hFF;
   localparam logic [7:0] FN_MAX        = 8'h45;
   localparam logic [7:0] ESTOP_TRIP_CODE = 8'h25;
   localparam logic [1:0] POL_NO = 2'h0;
   localparam logic [1:0] POL_NC = 2'h1;

   localparam logic [NUM_TERM-1:0][7:0] FUNC_RESET =
      {FN_NONE, FN_NONE, FN_NONE, FN_NONE, FN_NONE, FN_JOG, FN_NONE, FN_TRIP_RESET};

   // register offsets
   localparam logic [ADDR_W-1:0] ADDR_FUNC_LO  = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_FUNC_HI  = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_POL      = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_KEYPAD   = 8'h18;

   // interrupt bits
   localparam int NUM_IRQ     = 5;
   localparam int IRQ_TRIP    = 0;
   localparam int IRQ_CLEAR   = 1;
   localparam int IRQ_KP_REJ  = 2;
   localparam int IRQ_CFG_REJ = 3;
   localparam int IRQ_SWITCH  = 4;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } esi_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } esi_axi_rsp_t;

   typedef struct packed {
      logic [NUM_TERM:0]         sync1;
      logic [NUM_TERM:0]         sync2;
      logic [NUM_TERM:0]         prev;
      logic [NUM_TERM-1:0][7:0]  func;
      logic [NUM_TERM-1:0][1:0]  pol;
      logic                      trip;
      logic [7:0]                trip_code;
      logic                      drive_reset;
      logic [NUM_IRQ-1:0]        irq_stat;
      logic [NUM_IRQ-1:0]        irq_mask;
      logic                      aw_got;
      logic                      w_got;
      logic [ADDR_W-1:0]         awaddr;
      logic [31:0]               wdata;
      logic [3:0]                wstrb;
      logic                      bvalid;
      logic [1:0]                bresp;
      logic                      rvalid;
      logic [31:0]               rdata;
      logic [1:0]                rresp;
   } esi_state_t;
endpackage

// File: test/esi_interlock_asserts.sv
`timescale 1ns/1ps
module esi_asserts
   import esi_pkg::*;
#(
   parameter int NUM_GATE = 6
)
(
   // clock and reset
   input wire logic                sys_clk,
   input wire logic                resetn,
   // pins
   input wire logic [NUM_TERM-1:0] term_in,
   input wire logic                interlock_enable_switch,
   input wire logic [NUM_GATE-1:0] gate_cmd_in,
   // outputs
   input wire logic [NUM_GATE-1:0] gate_cmd_out,
   input wire logic                switching_halted,
   input wire logic                drive_reset,
   input wire logic [7:0]          estop_trip_code,
   input wire logic                interlock_active
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   logic trip;
   assign trip = estop_trip_code == ESTOP_TRIP_CODE;
   a_gate_block: assert property (switching_halted |-> gate_cmd_out == '0)
      else $error("gates pass while halted");
   a_gate_pass: assert property (!switching_halted |-> gate_cmd_out == gate_cmd_in)
      else $error("gates altered while running");
   a_raw_stop: assert property (interlock_enable_switch && !term_in[2] |-> switching_halted)
      else $error("open stop contact not halting");
   a_code_value: assert property (estop_trip_code != 8'h00 |-> trip)
      else $error("bad trip code");
   // sync plus latch needs a few cycles of open contact
   a_trip_latch: assert property ((interlock_active && !term_in[2]) [*5] |-> trip)
      else $error("stop open but no trip");
   a_trip_hold: assert property (trip && !term_in[2] && !$past(term_in[2])
      && !$past(term_in[2], 2) |=> trip) else $error("trip dropped with stop open");
   a_no_release: assert property (trip && !term_in[0] && !$past(term_in[0])
      && !$past(term_in[0], 2) |=> trip) else $error("trip dropped without reset");
   a_reset_pulse: assert property (drive_reset |=> !drive_reset)
      else $error("reset pulse too long");
   c_trip: cover property ($rose(trip));
   c_clear: cover property ($fell(trip));
   c_pulse: cover property (drive_reset);
endmodule

// File: test/esi_safety_model.sv
`timescale 1ns/1ps
module esi_safety_model
   import esi_pkg::*;
(
   // clock
   input wire logic                sys_clk,
   // demands from the bench
   input wire logic                stop_req,
   input wire logic                wire_cut,
   input wire logic                rst_go,
   input wire logic [3:0]          rst_len,
   input wire logic [NUM_TERM-1:0] other_in,
   // contacts, high = closed
   output logic     [NUM_TERM-1:0] term_in
);
   logic [3:0] cnt_ff = 4'h0;
   always @(posedge sys_clk)
   begin
      if (rst_go)
         cnt_ff <= rst_len;
      else if (cnt_ff != 4'h0)
         cnt_ff <= cnt_ff - 4'h1;
   end
   // a cut wire reads as an open contact
   always_comb
   begin
      term_in    = other_in;
      term_in[2] = !(stop_req || wire_cut);
      term_in[0] = cnt_ff != 4'h0;
   end
endmodule

// File: test/tb_emergency_stop_interlock.sv
`timescale 1ns/1ps
module tb_emergency_stop_interlock;
   import esi_pkg::*;
   logic                sys_clk = 1'b0;
   logic                resetn = 1'b0;
   logic                sw = 1'b0;
   logic                stop_req = 1'b0;
   logic                wire_cut = 1'b0;
   logic                rst_go = 1'b0;
   logic [NUM_TERM-1:0] term_in;
   logic [5:0]          gin = 6'h2D;
   logic [5:0]          gout;
   logic                halted;
   logic                drv_rst;
   logic [7:0]          code;
   logic                active;
   logic                irq;
   esi_axi_req_t        req = '0;
   esi_axi_rsp_t        rsp;
   int                  err_total = 0;
   int                  checked = 0;
   int                  cyc = 0;
   int                  pulses = 0;
   logic [31:0]         rd_d;
   logic [1:0]          resp;
   always #20 sys_clk = ~sys_clk;
   esi_safety_model esi_safety_model_i (.sys_clk, .stop_req, .wire_cut, .rst_go,
      .rst_len(4'h4), .other_in(8'h00), .term_in);
   esi_interlock esi_interlock_i (.sys_clk, .resetn, .term_in, .interlock_enable_switch(sw),
      .gate_cmd_in(gin), .gate_cmd_out(gout), .switching_halted(halted), .drive_reset(drv_rst),
      .estop_trip_code(code), .interlock_active(active), .irq, .axi_req(req), .axi_rsp(rsp));
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (drv_rst === 1'b1)
         pulses <= pulses + 1;
      if (cyc == 4000)
      begin
         err_total = err_total + 1;
         conclude();
      end
   end
   task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
      checked = checked + 1;
      if (got !== exp)
      begin
         err_total = err_total + 1;
         $display("wrong value %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw;
      logic w;
      aw = 1'b0;
      w = 1'b0;
      req.awaddr <= a;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      while (!(aw && w))
      begin
         @(posedge sys_clk);
         aw = aw | (rsp.awready === 1'b1);
         w = w | (rsp.wready === 1'b1);
         req.awvalid <= !aw;
         req.wvalid <= !w;
      end
      do @(posedge sys_clk); while (rsp.bvalid !== 1'b1);
      resp = rsp.bresp;
      // bready stays high so a following call never re-drives it in the same step
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string n);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do @(posedge sys_clk); while (rsp.arready !== 1'b1);
      req.arvalid <= 1'b0;
      do @(posedge sys_clk); while (rsp.rvalid !== 1'b1);
      rd_d = rsp.rdata;
      resp = rsp.rresp;
      // rready stays high for the same reason as bready
      chk(n, exp, rd_d);
   endtask
   task automatic pulse_rst();
      rst_go <= 1'b1;
      @(posedge sys_clk);
      rst_go <= 1'b0;
      repeat (9) @(posedge sys_clk);
   endtask
   task automatic t_defaults();
      rdc(ADDR_FUNC_LO, 32'hFF06FF12, "func_lo");
      rdc(ADDR_POL, 32'h0, "pol");
      rdc(8'h1C, 32'h0, "unmapped");
      chk("unmapped resp", 32'(RESP_SLVERR), 32'(resp));
      stop_req <= 1'b1;
      repeat (5) @(posedge sys_clk);
      chk("halt when off", 32'h0, 32'(halted));
      chk("gates pass", 32'(gin), 32'(gout));
      stop_req <= 1'b0;
   endtask
   task automatic t_enable();
      wr(ADDR_FUNC_LO, 32'hFF061212);
      chk("wr resp", 32'(RESP_OKAY), 32'(resp));
      sw <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk("active", 32'h1, 32'(active));
      rdc(ADDR_FUNC_LO, 32'hFF40FF12, "func_lo on");
      rdc(ADDR_POL, 32'h10, "pol on");
      wr(ADDR_FUNC_LO, 32'hFF06FF06);
      rdc(ADDR_FUNC_LO, 32'hFF40FF12, "func_lo locked");
   endtask
   task automatic t_stop();
      int n;
      wr(ADDR_IRQ_MASK, 32'h1);
      stop_req <= 1'b1;
      @(posedge sys_clk);
      #1 chk("gates", 32'h0, 32'(gout));
      repeat (4) @(posedge sys_clk);
      chk("trip", 32'(ESTOP_TRIP_CODE), 32'(code));
      chk("irq", 32'h1, 32'(irq));
      wr(ADDR_IRQ_STAT, 32'h1);
      chk("irq cleared", 32'h0, 32'(irq));
      n = pulses;
      pulse_rst();
      chk("held", 32'(ESTOP_TRIP_CODE), 32'(code));
      wr(ADDR_KEYPAD, 32'h1);
      stop_req <= 1'b0;
      repeat (5) @(posedge sys_clk);
      chk("keypad", 32'(ESTOP_TRIP_CODE), 32'(code));
      pulse_rst();
      chk("cleared", 32'h0, 32'(code));
      chk("pulses", 32'(n + 1), 32'(pulses));
   endtask
   task automatic t_wire();
      wire_cut <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk("cut wire", 32'(ESTOP_TRIP_CODE), 32'(code));
      wire_cut <= 1'b0;
      repeat (3) @(posedge sys_clk);
      pulse_rst();
      chk("cut cleared", 32'h0, 32'(code));
   endtask
   task automatic t_disable();
      sw <= 1'b0;
      repeat (6) @(posedge sys_clk);
      rdc(ADDR_FUNC_LO, 32'hFFFFFF12, "func_lo off");
      rdc(ADDR_POL, 32'h10, "pol off");
      wr(ADDR_FUNC_LO, 32'hFF40FF12);
      rdc(ADDR_FUNC_LO, 32'hFFFFFF12, "stop code");
      wr(ADDR_POL, 32'h11);
      rdc(ADDR_POL, 32'h10, "pol of reset");
   endtask
   initial
   begin
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      t_defaults();
      t_enable();
      t_stop();
      t_wire();
      t_disable();
      conclude();
   end
endmodule
bind esi_interlock esi_asserts #(.NUM_GATE(NUM_GATE)) esi_asserts_i (.sys_clk, .resetn,
   .term_in, .interlock_enable_switch, .gate_cmd_in, .gate_cmd_out, .switching_halted,
   .drive_reset, .estop_trip_code, .interlock_active);
